// *** hw/btsrl_exec.sv ***
`timescale 1ns/100ps
`include "btsrl_params.svh"
module btsrl_exec
    import btsrl_pkg::*;
(
    input  wire logic        clk,          // Core clock, 100 MHz.
    input  wire logic        sys_rst,      // Asynchronous reset, high.
    input  wire logic        clkEn,        // Freezes all state when low.
    input  wire logic        instrValid,   // An instruction sits in slot.
    input  wire logic [11:0] instrWord,    // Instruction word in slot.
    output logic      [4:0]  fileRdAddr,   // File read address.
    input  wire logic [7:0]  fileRdData,   // File read data, same cycle.
    output logic             fileWrEn,     // File write strobe.
    output logic      [4:0]  fileWrAddr,   // File write address.
    output logic      [7:0]  fileWrData,   // File write data.
    output logic      [7:0]  wData,        // Working register.
    output logic             carryFlag,    // Status bit 0.
    output logic             squashNext,   // Discard the prefetch.
    output logic             nopSlot       // Slot runs as no-op.
);

    btsrl_state_t state;
    btsrl_state_t next_state;

    logic       slotGo;
    logic       isTest;
    logic       isRot;
    logic       execTest;
    logic       execRot;
    logic [2:0] bitIdx;
    logic       destFile;
    logic       bitVal;

    btsrl_rot_if rotBus ();

    btsrl_rotator u_rotator (
        .rot (rotBus.unit)
    );

    // Field extraction; reads happen while the word sits in the slot.
    // The file read is combinational, so the tested bit and the rotate
    // operand both belong to the word that is in the slot right now.
    assign bitIdx     = instrWord[`BTSRL_BIT_HI:`BTSRL_BIT_LO];
    assign destFile   = instrWord[`BTSRL_DEST_POS];
    assign fileRdAddr = instrWord[`BTSRL_FILE_HI:`BTSRL_FILE_LO];
    assign bitVal     = fileRdData[bitIdx];

    // Decode of the two instructions handled here.
    // Words that match neither prefix fall through and change nothing.
    assign isTest = instrWord[`BTSRL_OPC_TEST_HI:`BTSRL_OPC_TEST_LO]
                    == `BTSRL_OPC_TEST;
    assign isRot  = instrWord[`BTSRL_OPC_ROT_HI:`BTSRL_OPC_ROT_LO]
                    == `BTSRL_OPC_ROT;

    // A squashed slot must not act, even if it decodes as ours.
    assign slotGo   = clkEn && instrValid && (state.mode == BTSRL_EXEC);
    assign execTest = slotGo && isTest;
    assign execRot  = slotGo && isRot;

    // Rotator operands come straight from the file and carry.
    assign rotBus.operand = fileRdData;
    assign rotBus.carryIn = state.carry;

    // Next-state logic. Every field but the write strobe and the discard pulse keeps
    // its value unless a slot of ours acts on it, which is what makes the clock-enable freeze cheap.
    always_comb begin
        next_state        = state;
        next_state.fileWr = 1'b0;
        if (clkEn) begin
            next_state.squash = 1'b0;
        end
        if (clkEn && instrValid && state.mode == BTSRL_SQUASH) begin
            // The prefetched word is dropped; this slot is a no-op.
            next_state.mode = BTSRL_EXEC;
        end
        if (execTest && bitVal) begin
            // Skip taken: second cycle spent on a no-op slot.
            next_state.mode   = BTSRL_SQUASH;
            next_state.squash = 1'b1;
        end
        if (execRot) begin
            next_state.carry = rotBus.carryOut;
            if (destFile) begin
                next_state.fileWr     = 1'b1;
                next_state.fileWrAddr = fileRdAddr;
                next_state.fileWrData = rotBus.result;
            end else begin
                next_state.wReg = rotBus.result;
            end
        end
        if (!clkEn) begin
            // Frozen clock enable also holds the write strobe.
            next_state.fileWr = state.fileWr;
        end
    end

    // State register. A reset drops any pending skip, so the first slot
    // after release always executes; a stale skip would eat a real word.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state            <= '0;
            state.mode       <= BTSRL_EXEC;
            state.carry      <= `BTSRL_RST_CARRY;
            state.wReg       <= `BTSRL_RST_W;
            state.fileWrAddr <= `BTSRL_RST_ADDR;
            state.fileWrData <= `BTSRL_RST_DATA;
        end else begin
            state <= next_state;
        end
    end

    // Outputs from the state register; no-op marker is a handshake.
    // Strobe, address and data of a write all leave one register, so the
    // file sees them change together on a single edge.
    assign fileWrEn   = state.fileWr;
    assign fileWrAddr = state.fileWrAddr;
    assign fileWrData = state.fileWrData;
    assign wData      = state.wReg;
    assign carryFlag  = state.carry;
    assign squashNext = state.squash;
    assign nopSlot    = instrValid && (state.mode == BTSRL_SQUASH);

    // Helper terms computed independently of the datapath above.
    logic       selHit;
    logic [7:0] rotExpect;
    logic       msbIn;
    assign selHit    = (fileRdData & (`BTSRL_ONE_HOT_LSB << bitIdx))
                       != 8'h00;
    assign rotExpect = {fileRdData[6:0], carryFlag};
    assign msbIn     = fileRdData[7];

    // All checks share the core clock and rest while reset is high. The
    // helper terms are rebuilt from the pins, so a fault in the shared
    // rotator cannot hide itself behind its own output.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_skip_taken: assert property (
        execTest && bitVal |=> nopSlot || !instrValid ##0
        squashNext ##0 (state.mode == BTSRL_SQUASH))
        else $error("Set bit did not start a skip.");

    chk_no_skip: assert property (
        execTest && !bitVal |=> !squashNext && state.mode == BTSRL_EXEC)
        else $error("Clear bit started a skip.");

    chk_squash_slot: assert property (
        clkEn && instrValid && state.mode == BTSRL_SQUASH |=>
        state.mode == BTSRL_EXEC && !fileWrEn && $stable(carryFlag)
        && $stable(wData))
        else $error("Squashed slot changed state.");

    chk_test_flags: assert property (
        execTest |=> $stable(carryFlag) && $stable(wData) && !fileWrEn)
        else $error("Bit test changed flags or registers.");

    chk_index_reach: assert property (
        execTest |=> squashNext == $past(selHit))
        else $error("Wrong bit selected by the test.");

    chk_rot_carry: assert property (
        execRot |=> carryFlag == $past(msbIn))
        else $error("Carry did not take old bit 7.");

    chk_rot_to_w: assert property (
        execRot && !destFile |=> wData == $past(rotExpect) && !fileWrEn)
        else $error("Rotate to W went wrong.");

    chk_rot_to_file: assert property (
        execRot && destFile |=> fileWrEn && $stable(wData)
        && fileWrData == $past(rotExpect)
        && fileWrAddr == $past(fileRdAddr))
        else $error("Rotate to file went wrong.");

    chk_squash_pulse: assert property (
        squashNext && clkEn |=> !squashNext)
        else $error("Discard pulse lasted too long.");

    // A frozen clock enable holds every registered output, a pending
    // skip included, so a stalled core resumes exactly where it stopped.
    chk_freeze_hold: assert property (
        !clkEn |=> $stable(wData) && $stable(carryFlag)
        && $stable(fileWrEn) && $stable(squashNext)
        && $stable(fileWrData) && $stable(fileWrAddr))
        else $error("State moved while the clock enable was low.");

    // Words of other instructions must leave this unit untouched.
    chk_other_word: assert property (
        slotGo && !isTest && !isRot |=> $stable(wData)
        && $stable(carryFlag) && !fileWrEn && !squashNext)
        else $error("Foreign word changed state.");

    // A rotate takes one slot and never starts a skip.
    chk_rot_single: assert property (
        execRot |=> !squashNext && state.mode == BTSRL_EXEC)
        else $error("Rotate took more than one slot.");

    // The write strobe lasts one enabled cycle unless a rotate renews it.
    chk_write_pulse: assert property (
        fileWrEn && clkEn && !(execRot && destFile) |=> !fileWrEn)
        else $error("Write strobe lasted too long.");

    // A no-op slot must be a real slot and must not write the file.
    chk_nop_quiet: assert property (
        nopSlot |-> instrValid && !fileWrEn)
        else $error("No-op marker without a quiet slot.");

    // Scenario covers: a skip, both destinations, a frozen skip and a
    // test straight after a squashed slot.
    cov_skip: cover property (execTest && bitVal ##1 nopSlot);
    cov_rot_w: cover property (execRot && !destFile);
    cov_rot_f: cover property (execRot && destFile);
    cov_back: cover property (
        state.mode == BTSRL_SQUASH && clkEn && instrValid
        ##1 execTest);
    cov_freeze: cover property (squashNext && !clkEn ##1 nopSlot);

endmodule : btsrl_exec

// *** hw/btsrl_params.svh ***
`ifndef BTSRL_PARAMS_SVH
`define BTSRL_PARAMS_SVH
// Instruction word fields.
`define BTSRL_OPC_TEST     4'h7
`define BTSRL_OPC_TEST_HI  11
`define BTSRL_OPC_TEST_LO  8
`define BTSRL_OPC_ROT      6'h0d
`define BTSRL_OPC_ROT_HI   11
`define BTSRL_OPC_ROT_LO   6
`define BTSRL_BIT_HI       7
`define BTSRL_BIT_LO       5
`define BTSRL_DEST_POS     5
`define BTSRL_FILE_HI      4
`define BTSRL_FILE_LO      0
// Data operand fields.
`define BTSRL_MSB_POS      7
`define BTSRL_ONE_HOT_LSB  8'h01
// Reset values.
`define BTSRL_RST_CARRY    1'h0
`define BTSRL_RST_W        8'h00
`define BTSRL_RST_ADDR     5'h00
`define BTSRL_RST_DATA     8'h00
`endif

// *** hw/btsrl_pkg.sv ***
package btsrl_pkg;

    // Execute slot or a slot that runs as a no-operation.
    typedef enum logic [0:0] {
        BTSRL_EXEC   = 1'b0,
        BTSRL_SQUASH = 1'b1
    } btsrl_mode_t;

    // Complete state of the execute unit.
    typedef struct packed {
        btsrl_mode_t mode;
        logic        carry;
        logic [7:0]  wReg;
        logic        fileWr;
        logic [4:0]  fileWrAddr;
        logic [7:0]  fileWrData;
        logic        squash;
    } btsrl_state_t;

endpackage : btsrl_pkg

// *** hw/btsrl_rot_if.sv ***
`timescale 1ns/100ps
interface btsrl_rot_if;
    logic [7:0] operand;
    logic       carryIn;
    logic [7:0] result;
    logic       carryOut;

    modport unit (input operand, input carryIn,
                  output result, output carryOut);
    modport user (output operand, output carryIn,
                  input result, input carryOut);
endinterface : btsrl_rot_if

// *** hw/btsrl_rotator.sv ***
`timescale 1ns/100ps
module btsrl_rotator (
    btsrl_rot_if.unit rot   // Operand in, rotated value out.
);
    // Old carry enters bit 0 and old bit 7 leaves as the new carry.
    assign rot.result   = {rot.operand[6:0], rot.carryIn};
    assign rot.carryOut = rot.operand[`BTSRL_MSB_POS];
endmodule : btsrl_rotator

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench
    import btsrl_pkg::*;
;
    // One slot per row: word, file data, then W, carry, write and its data.
    typedef struct packed {
        logic [11:0] word;
        logic [7:0]  rd;
        logic [7:0]  w;
        logic        c;
        logic        we;
        logic [7:0]  wd;
    } btsrl_row_t;

    localparam btsrl_row_t ROWS [6] = '{
        '{12'h345, 8'he6, 8'hcc, 1'h1, 1'h0, 8'h00},
        '{12'h37f, 8'h01, 8'hcc, 1'h0, 1'h1, 8'h03},
        '{12'h7e0, 8'h7f, 8'hcc, 1'h0, 1'h0, 8'h00},
        '{12'h350, 8'h80, 8'h00, 1'h1, 1'h0, 8'h00},
        '{12'h000, 8'hff, 8'h00, 1'h1, 1'h0, 8'h00},
        '{12'h36a, 8'h55, 8'h00, 1'h0, 1'h1, 8'hab}};

    logic        clk;
    logic        sys_rst;
    logic        clkEn;
    logic        instrValid;
    logic [11:0] instrWord;
    logic [7:0]  fileRdData;
    logic [4:0]  fileRdAddr;
    logic        fileWrEn;
    logic [4:0]  fileWrAddr;
    logic [7:0]  fileWrData;
    logic [7:0]  wData;
    logic        carryFlag;
    logic        squashNext;
    logic        nopSlot;
    int          badCount = 0;
    int          cmpCount = 0;

    // The bench owns every input, the clock enable included.
    btsrl_exec u_btsrl_exec (
        .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .instrValid(instrValid), .instrWord(instrWord),
        .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
        .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData), .wData(wData), .carryFlag(carryFlag),
        .squashNext(squashNext), .nopSlot(nopSlot));

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic endSim;
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : endSim

    // Drives a slot after the falling edge, so the rising edge sees it settled.
    task automatic drive(input logic [11:0] word, input logic [7:0] rd);
        @(negedge clk);
        instrValid = 1'b1;
        instrWord  = word;
        fileRdData = rd;
        #1 chk(fileRdAddr, word[4:0]);
    endtask : drive

    task automatic idle;
        @(negedge clk);
        instrValid = 1'b0;
        #1;
    endtask : idle

    // Hang guard, well above the fewer than a hundred cycles the tests need.
    initial begin
        #20000;
        badCount++;
        endSim();
    end

    initial begin
        logic [7:0] w;
        logic       c;
        logic [2:0] bi;
        logic [4:0] fa;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        instrValid = 1'b0;
        instrWord = 12'h000;
        fileRdData = 8'h00;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        // Isolated slots; each result is read one cycle later.
        foreach (ROWS[i]) begin
            drive(ROWS[i].word, ROWS[i].rd);
            idle();
            chk(wData, ROWS[i].w);
            chk(carryFlag, ROWS[i].c);
            chk(fileWrEn, ROWS[i].we);
            chk(squashNext, 1'h0);
            if (ROWS[i].we) chk(fileWrAddr, ROWS[i].word[4:0]);
            if (ROWS[i].we) chk(fileWrData, ROWS[i].wd);
        end
        w = 8'h00;
        c = 1'b0;
        // Every bit index, clear then set, with a rotate left behind it.
        for (int i = 0; i < 8; i++) begin
            bi = i[2:0];
            fa = 5'(i * 4 + 3);
            drive({4'h7, bi, fa}, ~(8'h01 << bi));
            drive(12'h345, 8'h80);
            chk(nopSlot, 1'h0);
            w = {7'h00, c};
            c = 1'b1;
            idle();
            chk(wData, w);
            chk(carryFlag, c);
            drive({4'h7, bi, fa}, 8'h01 << bi);
            drive(12'h345, 8'hff);
            chk(squashNext, 1'h1);
            chk(nopSlot, 1'h1);
            idle();
            chk(squashNext, 1'h0);
            chk(wData, w);
            chk(carryFlag, c);
            chk(fileWrEn, 1'h0);
        end
        // A frozen enable holds a file write strobe in place.
        drive(12'h37f, 8'h80);
        @(negedge clk);
        instrValid = 1'b0;
        clkEn = 1'b0;
        repeat (2) @(negedge clk);
        chk(fileWrEn, 1'h1);
        chk(fileWrData, 8'h01);
        chk(carryFlag, 1'h1);
        clkEn = 1'b1;
        idle();
        chk(fileWrEn, 1'h0);
        // A skip stays pending while frozen and then eats the next slot.
        drive({4'h7, 3'h7, 5'h02}, 8'h80);
        @(negedge clk);
        clkEn = 1'b0;
        instrWord = 12'h345;
        fileRdData = 8'hff;
        repeat (2) @(negedge clk);
        chk(squashNext, 1'h1);
        chk(nopSlot, 1'h1);
        clkEn = 1'b1;
        idle();
        chk(squashNext, 1'h0);
        chk(wData, 8'h01);
        chk(carryFlag, 1'h1);
        // A reset in mid-run clears state and a pending skip at once.
        drive({4'h7, 3'h0, 5'h03}, 8'h01);
        @(negedge clk);
        sys_rst = 1'b1;
        #1 chk(wData, 8'h00);
        chk(carryFlag, 1'h0);
        chk(squashNext, 1'h0);
        chk(nopSlot, 1'h0);
        // The first slot after release executes, with a cleared carry.
        @(negedge clk);
        sys_rst = 1'b0;
        instrWord = 12'h37f;
        fileRdData = 8'h81;
        #1 chk(nopSlot, 1'h0);
        idle();
        chk(fileWrEn, 1'h1);
        chk(fileWrData, 8'h02);
        chk(carryFlag, 1'h1);
        chk(wData, 8'h00);
        chk(squashNext, 1'h0);
        endSim();
    end
endmodule : testbench
